// ### rtl/dct_addr_step.sv
// Purpose: Next value of one address pointer after a transfer cycle.
// Assumes: Pointer wraps modulo two to the twenty-fourth.
// Notes: Purely combinational; the caller decides when to take the value.
`timescale 1ns/10ps
module dct_addr_step (
    input wire logic [23:0] i_addr,
    input wire logic i_en,
    input wire logic [1:0] i_size,
    output logic [23:0] o_addr
);

    logic [23:0] delta;

    // Decrements are formed by adding the two's complement step.
    always_comb begin
        unique case (i_size)
            dct_pkg::STEP_INC1: delta = 24'h000001;
            dct_pkg::STEP_INC2: delta = 24'h000002;
            dct_pkg::STEP_DEC1: delta = 24'hFFFFFF;
            dct_pkg::STEP_DEC2: delta = 24'hFFFFFE;
        endcase
        o_addr = i_en ? i_addr + delta : i_addr;
    end

endmodule

// ### rtl/dct_channel.sv
// Purpose: One DMA channel with pointers, length counter, control, status.
// Assumes: System bus on i_sys_clk; peripheral request is asynchronous.
// Notes: Software writes to pointers and counters win over hardware steps.
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module dct_channel (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    input wire logic i_hw_req,
    input wire logic i_bus_grant,
    input wire logic i_bus_ack,
    input wire logic [15:0] i_bus_rdata,
    output logic o_bus_req,
    output logic o_bus_rd,
    output logic o_bus_wr,
    output logic o_bus_word,
    output logic [23:0] o_bus_addr,
    output logic [15:0] o_bus_wdata,
    output logic o_flyby_ack,
    output logic o_irq,
    output logic o_dma_clk_en
);

    typedef struct packed {
        dct_pkg::dct_state_t st;
        logic req_s1;
        logic req_s2;
        logic [23:0] a_cur;
        logic [23:0] a_start;
        logic [23:0] b_cur;
        logic [23:0] b_start;
        logic [15:0] len_cur;
        logic [15:0] len_next;
        logic [15:0] ctrl;
        logic term_flag;
        logic overrun_flag;
        logic params_valid_flag;
        logic [15:0] data;
        logic [31:0] rdata;
        logic bus_req;
        logic bus_rd;
        logic bus_wr;
        logic bus_word;
        logic [23:0] bus_addr;
        logic [15:0] bus_wdata;
        logic flyby_ack;
        logic irq;
        logic clk_en;
    } dct_regs_t;

    dct_regs_t q;
    dct_regs_t n;
    logic [23:0] a_stepped;
    logic [23:0] b_stepped;

    // Pointer stepping; both units look at the registered control fields.
    dct_addr_step u_step_a (
        .i_addr(q.a_cur),
        .i_en(q.ctrl[dct_pkg::CTL_A_STEP_EN]),
        .i_size(q.ctrl[dct_pkg::CTL_A_STEP_LO +: 2]),
        .o_addr(a_stepped)
    );

    dct_addr_step u_step_b (
        .i_addr(q.b_cur),
        .i_en(q.ctrl[dct_pkg::CTL_B_STEP_EN]),
        .i_size(q.ctrl[dct_pkg::CTL_B_STEP_LO +: 2]),
        .o_addr(b_stepped)
    );

    // All next-state logic; the bus outputs are derived from the next state
    // so that every port is a flip-flop and still lines up with its state.
    always_comb begin
        logic enabled;
        logic active;
        logic want;
        logic mem2mem;
        logic direction;
        logic last;
        logic load_next;
        logic set_term;
        logic set_overrun;
        logic clr_valid;
        logic set_valid;
        logic wr_hit;
        dct_pkg::dct_state_t first;
        enabled = 1'b0;
        active = 1'b0;
        want = 1'b0;
        mem2mem = 1'b0;
        direction = 1'b0;
        last = 1'b0;
        load_next = 1'b0;
        set_term = 1'b0;
        set_overrun = 1'b0;
        clr_valid = 1'b0;
        set_valid = 1'b0;
        wr_hit = 1'b0;
        first = dct_pkg::ST_READ;
        n = q;

        // Only the second stage of the synchroniser is looked at.
        n.req_s1 = i_hw_req;
        n.req_s2 = q.req_s1;

        enabled = q.ctrl[dct_pkg::CTL_CHANNEL_ENABLE];
        active = enabled && (q.len_cur != dct_pkg::LEN_ZERO);
        want = active
            && (q.req_s2 || q.ctrl[dct_pkg::CTL_SOFTWARE_REQUEST]);
        mem2mem = q.ctrl[dct_pkg::CTL_MEM_TO_MEM];
        direction = q.ctrl[dct_pkg::CTL_DIRECTION];
        last = (q.len_cur == dct_pkg::LEN_ONE);

        // Fly-by does one bus cycle whose kind follows the direction.
        if (!mem2mem && direction) begin
            first = dct_pkg::ST_WRITE;
        end

        // Transfer sequencer.
        unique case (q.st)
            dct_pkg::ST_IDLE: begin
                if (want) begin
                    n.st = dct_pkg::ST_GRANT;
                end
            end
            dct_pkg::ST_GRANT: begin
                if (!active) begin
                    n.st = dct_pkg::ST_IDLE;
                end else if (i_bus_grant) begin
                    n.st = first;
                end
            end
            dct_pkg::ST_READ: begin
                if (i_bus_ack) begin
                    if (q.ctrl[dct_pkg::CTL_TRANSFER_SIZE]) begin
                        n.data = i_bus_rdata;
                    end else begin
                        n.data = {8'h00, i_bus_rdata[7:0]};
                    end
                    n.st = mem2mem ? dct_pkg::ST_WRITE : dct_pkg::ST_STEP;
                end
            end
            dct_pkg::ST_WRITE: begin
                if (i_bus_ack) begin
                    n.st = dct_pkg::ST_STEP;
                end
            end
            dct_pkg::ST_STEP: begin
                n.a_cur = a_stepped;
                if (mem2mem) begin
                    n.b_cur = b_stepped;
                end
                n.len_cur = q.len_cur - dct_pkg::LEN_ONE;
                if (last) begin
                    set_term = 1'b1;
                    if (q.ctrl[dct_pkg::CTL_OPERATION_TYPE]) begin
                        set_overrun = q.term_flag;
                        load_next = 1'b1;
                    end else begin
                        set_overrun = !q.params_valid_flag;
                        load_next = q.params_valid_flag;
                    end
                end
                // A one-cycle trip through idle drops the bus request.
                if (q.ctrl[dct_pkg::CTL_BUS_POLICY] && want && !last) begin
                    n.st = first;
                end else begin
                    n.st = dct_pkg::ST_IDLE;
                end
            end
            default: n.st = dct_pkg::ST_IDLE;
        endcase

        // A fresh enable on an exhausted channel starts the queued block.
        if (i_reg_wr && (i_reg_addr == dct_pkg::ADR_CTRL)
            && i_reg_wdata[dct_pkg::CTL_CHANNEL_ENABLE]
            && (q.len_cur == dct_pkg::LEN_ZERO) && q.params_valid_flag) begin
            load_next = 1'b1;
        end

        // Block reload; the B pointer is left alone in fly-by mode.
        if (load_next) begin
            n.a_cur = q.a_start;
            if (mem2mem) begin
                n.b_cur = q.b_start;
            end
            if (q.len_next == dct_pkg::LEN_ZERO) begin
                n.len_cur = dct_pkg::LEN_ZERO_AS;
            end else begin
                n.len_cur = q.len_next;
            end
            clr_valid = 1'b1;
        end

        // Register writes; these take priority over hardware updates.
        if (i_reg_wr) begin
            wr_hit = 1'b1;
            unique case (i_reg_addr)
                dct_pkg::ADR_A_CUR: n.a_cur = i_reg_wdata[23:0];
                dct_pkg::ADR_A_START: n.a_start = i_reg_wdata[23:0];
                dct_pkg::ADR_B_CUR: n.b_cur = i_reg_wdata[23:0];
                dct_pkg::ADR_B_START: n.b_start = i_reg_wdata[23:0];
                dct_pkg::ADR_LEN_CUR: begin
                    if (i_reg_wdata[15:0] == dct_pkg::LEN_ZERO) begin
                        n.len_cur = dct_pkg::LEN_ZERO_AS;
                    end else begin
                        n.len_cur = i_reg_wdata[15:0];
                    end
                end
                dct_pkg::ADR_LEN_NEXT: begin
                    n.len_next = i_reg_wdata[15:0];
                    set_valid = 1'b1;
                end
                dct_pkg::ADR_CTRL: begin
                    n.ctrl = i_reg_wdata[15:0]
                        & dct_pkg::CTRL_WRITE_MASK;
                end
                dct_pkg::ADR_STAT: begin
                    // The active flag is computed, so writes cannot touch it.
                    if (i_reg_wdata[dct_pkg::STA_PARAMS_VALID]) begin
                        clr_valid = 1'b1;
                    end
                end
                default: wr_hit = 1'b0;
            endcase
        end

        // Sticky flags: a hardware set wins over a clear in the same cycle.
        if (wr_hit && (i_reg_addr == dct_pkg::ADR_STAT)
            && i_reg_wdata[dct_pkg::STA_TERM]) begin
            n.term_flag = 1'b0;
        end
        if (wr_hit && (i_reg_addr == dct_pkg::ADR_STAT)
            && i_reg_wdata[dct_pkg::STA_OVERRUN]) begin
            n.overrun_flag = 1'b0;
        end
        if (clr_valid) begin
            n.params_valid_flag = 1'b0;
        end
        if (set_term) begin
            n.term_flag = 1'b1;
        end
        if (set_overrun) begin
            n.overrun_flag = 1'b1;
        end
        if (set_valid) begin
            n.params_valid_flag = 1'b1;
        end

        // Read data stands only in the cycle after the strobe.
        n.rdata = 32'h00000000;
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                dct_pkg::ADR_A_CUR: n.rdata = {8'h00, q.a_cur};
                dct_pkg::ADR_A_START: n.rdata = {8'h00, q.a_start};
                dct_pkg::ADR_B_CUR: n.rdata = {8'h00, q.b_cur};
                dct_pkg::ADR_B_START: n.rdata = {8'h00, q.b_start};
                dct_pkg::ADR_LEN_CUR: n.rdata = {16'h0000, q.len_cur};
                dct_pkg::ADR_LEN_NEXT: n.rdata = {16'h0000, q.len_next};
                dct_pkg::ADR_CTRL: n.rdata = {16'h0000, q.ctrl};
                dct_pkg::ADR_STAT: begin
                    n.rdata = {28'h0000000, q.params_valid_flag, active,
                        q.overrun_flag, q.term_flag};
                end
                default: n.rdata = 32'h00000000;
            endcase
        end

        // Bus outputs follow the state about to be entered.
        n.bus_req = (n.st != dct_pkg::ST_IDLE);
        n.bus_rd = (n.st == dct_pkg::ST_READ);
        n.bus_wr = (n.st == dct_pkg::ST_WRITE);
        n.bus_word = n.ctrl[dct_pkg::CTL_TRANSFER_SIZE];
        n.flyby_ack = !n.ctrl[dct_pkg::CTL_MEM_TO_MEM]
            && (n.bus_rd || n.bus_wr);
        n.bus_wdata = n.data;
        if (!n.ctrl[dct_pkg::CTL_MEM_TO_MEM]) begin
            n.bus_addr = n.a_cur;
        end else if (n.bus_wr == n.ctrl[dct_pkg::CTL_DIRECTION]) begin
            n.bus_addr = n.a_cur;
        end else begin
            n.bus_addr = n.b_cur;
        end
        n.irq = (n.term_flag && n.ctrl[dct_pkg::CTL_TERM_IRQ_EN])
            || (n.overrun_flag
            && n.ctrl[dct_pkg::CTL_OVERRUN_IRQ_EN]);
        n.clk_en = n.ctrl[dct_pkg::CTL_CHANNEL_ENABLE];
    end

    // Single register stage; reset clears everything to zero.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // Ports come straight from the state register.
    assign o_reg_rdata = q.rdata;
    assign o_bus_req = q.bus_req;
    assign o_bus_rd = q.bus_rd;
    assign o_bus_wr = q.bus_wr;
    assign o_bus_word = q.bus_word;
    assign o_bus_addr = q.bus_addr;
    assign o_bus_wdata = q.bus_wdata;
    assign o_flyby_ack = q.flyby_ack;
    assign o_irq = q.irq;
    assign o_dma_clk_en = q.clk_en;

endmodule

// ### rtl/dct_pkg.sv
// Purpose: Shared constants and types for the DMA channel transfer control.
// Assumes: One channel, 32-bit register port, 24-bit system bus addresses.
// Notes: Register indices are scaled by four to form byte addresses.
package dct_pkg;

    localparam int ADDR_W = 24;
    localparam int DATA_W = 32;
    localparam int REG_AW = 8;
    localparam int LEN_W = 16;
    localparam int CTRL_W = 16;
    localparam int XFER_W = 16;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_A_CUR = 8'h00;
    localparam logic [7:0] IDX_A_START = 8'h04;
    localparam logic [7:0] IDX_B_CUR = 8'h08;
    localparam logic [7:0] IDX_B_START = 8'h0C;
    localparam logic [7:0] IDX_LEN_CUR = 8'h10;
    localparam logic [7:0] IDX_LEN_NEXT = 8'h14;
    localparam logic [7:0] IDX_CTRL = 8'h1C;
    localparam logic [7:0] IDX_STAT = 8'h1E;
    localparam logic [7:0] ADR_A_CUR = {IDX_A_CUR[5:0], 2'b00};
    localparam logic [7:0] ADR_A_START = {IDX_A_START[5:0], 2'b00};
    localparam logic [7:0] ADR_B_CUR = {IDX_B_CUR[5:0], 2'b00};
    localparam logic [7:0] ADR_B_START = {IDX_B_START[5:0], 2'b00};
    localparam logic [7:0] ADR_LEN_CUR = {IDX_LEN_CUR[5:0], 2'b00};
    localparam logic [7:0] ADR_LEN_NEXT = {IDX_LEN_NEXT[5:0], 2'b00};
    localparam logic [7:0] ADR_CTRL = {IDX_CTRL[5:0], 2'b00};
    localparam logic [7:0] ADR_STAT = {IDX_STAT[5:0], 2'b00};

    // Channel control field positions.
    localparam int CTL_CHANNEL_ENABLE = 0;
    localparam int CTL_TERM_IRQ_EN = 1;
    localparam int CTL_OVERRUN_IRQ_EN = 2;
    localparam int CTL_TRANSFER_SIZE = 3;
    localparam int CTL_MEM_TO_MEM = 4;
    localparam int CTL_DIRECTION = 5;
    localparam int CTL_OPERATION_TYPE = 6;
    localparam int CTL_BUS_POLICY = 7;
    localparam int CTL_SOFTWARE_REQUEST = 8;
    localparam int CTL_A_STEP_EN = 9;
    localparam int CTL_A_STEP_LO = 10;
    localparam int CTL_B_STEP_EN = 12;
    localparam int CTL_B_STEP_LO = 13;
    localparam logic [15:0] CTRL_WRITE_MASK = 16'h7FFF;

    // Channel status field positions.
    localparam int STA_TERM = 0;
    localparam int STA_OVERRUN = 1;
    localparam int STA_ACTIVE = 2;
    localparam int STA_PARAMS_VALID = 3;

    // Values after reset and counter constants.
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] LEN_ONE = 16'h0001;
    localparam logic [15:0] LEN_ZERO = 16'h0000;
    localparam logic [15:0] LEN_ZERO_AS = 16'hFFFF;

    // Address step encodings.
    localparam logic [1:0] STEP_INC1 = 2'h0;
    localparam logic [1:0] STEP_INC2 = 2'h1;
    localparam logic [1:0] STEP_DEC1 = 2'h2;
    localparam logic [1:0] STEP_DEC2 = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_GRANT = 3'h1,
        ST_READ = 3'h3,
        ST_WRITE = 3'h2,
        ST_STEP = 3'h6
    } dct_state_t;

endpackage

// ### sim/dct_bus_model.sv
// Purpose: System bus arbiter and memory seen by the DMA channel.
// Assumes: Grant follows request one cycle later and holds while requested.
// Notes: Read data is the low 16 address bits at acknowledge; elsewhere it toggles each cycle.
`timescale 1ns/10ps
module dct_bus_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_req,
    input wire logic i_cyc,
    input wire logic [23:0] i_addr,
    input wire logic [3:0] i_dly,
    output logic o_grant,
    output logic o_ack,
    output logic [15:0] o_rdata
);
    logic [3:0] cnt;

    // Acknowledge each cycle after i_dly waits, slow or prompt.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_grant <= 1'b0;
            o_ack <= 1'b0;
            o_rdata <= 16'h0000;
            cnt <= 4'h0;
        end else begin
            o_grant <= i_req;
            o_ack <= 1'b0;
            o_rdata <= ~o_rdata;
            if (i_cyc && !o_ack) begin
                if (cnt == i_dly) begin
                    o_ack <= 1'b1;
                    o_rdata <= i_addr[15:0];
                    cnt <= 4'h0;
                end else begin
                    cnt <= cnt + 4'h1;
                end
            end
        end
    end
endmodule

// ### sim/dct_channel_monitor.sv
// Purpose: Port-level properties of the DMA channel.
// Assumes: One clock domain; bound to dct_channel from the bench.
// Notes: Internal registers are unseen, so only port relations are checked.
`timescale 1ns/10ps
module dct_channel_monitor (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_reg_rd,
    input wire logic [31:0] o_reg_rdata,
    input wire logic i_bus_grant,
    input wire logic i_bus_ack,
    input wire logic o_bus_req,
    input wire logic o_bus_rd,
    input wire logic o_bus_wr,
    input wire logic o_bus_word,
    input wire logic [23:0] o_bus_addr,
    input wire logic [15:0] o_bus_wdata,
    input wire logic o_flyby_ack,
    input wire logic o_dma_clk_en
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_sys_rst);

    // The acknowledge that ends a transfer, then the step cycle behind it.
    sequence s_last_ack;
        i_bus_ack && (o_bus_wr || (o_bus_rd && o_flyby_ack));
    endsequence
    sequence s_step;
        o_bus_req && !o_bus_rd && !o_bus_wr;
    endsequence

    a_cycle_hold: assert property (
        (o_bus_rd || o_bus_wr) && !i_bus_ack |=> $stable(o_bus_addr)
        && $stable(o_bus_word) && $stable({o_bus_rd, o_bus_wr}))
        else $error("bus cycle changed before acknowledge");
    a_step_cycle: assert property (s_last_ack |=> s_step)
        else $error("no step cycle after last acknowledge");
    a_after_step: assert property (
        s_last_ack ##1 s_step |=> !o_bus_req || o_bus_rd || o_bus_wr)
        else $error("step cycle lasted too long");
    a_cycle_granted: assert property (
        $rose(o_bus_rd) || $rose(o_bus_wr) |-> $past(i_bus_grant) && o_bus_req)
        else $error("bus cycle without grant");
    a_rdata_quiet: assert property (
        !$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
        else $error("read data outside its cycle");
    a_one_kind: assert property (!(o_bus_rd && o_bus_wr))
        else $error("read and write together");
    a_flyby_cycle: assert property (
        o_flyby_ack |-> o_bus_rd ^ o_bus_wr)
        else $error("fly-by acknowledge outside a cycle");
    a_byte_wdata: assert property (
        o_bus_wr && !o_bus_word |-> o_bus_wdata[15:8] == 8'h00)
        else $error("byte write carries upper data");
    a_off_quiet: assert property (
        !o_dma_clk_en && !o_bus_req |=> !o_bus_req)
        else $error("request while channel disabled");
    a_reset_quiet: assert property (disable iff (1'b0)
        i_sys_rst |=> !o_bus_req && !o_dma_clk_en && o_reg_rdata == 32'h0)
        else $error("outputs active after reset");
endmodule

// ### sim/tb_dct_channel.sv
// Purpose: Self-checking bench for the DMA channel.
// Assumes: Register port as in the package map; bus model as far side.
// Notes: Bus cycles are logged at their acknowledge; all but the third auto-init read are compared later.
`timescale 1ns/10ps
module tb_dct_channel;
    logic i_sys_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [7:0] i_reg_addr = 8'h00;
    logic [31:0] i_reg_wdata = 32'h0000_0000;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic i_hw_req = 1'b0;
    logic [3:0] dly = 4'h0;
    logic i_bus_grant, i_bus_ack, o_bus_req, o_bus_rd, o_bus_wr, o_bus_word;
    logic o_flyby_ack, o_irq, o_dma_clk_en, req_d;
    logic [15:0] i_bus_rdata, o_bus_wdata;
    logic [23:0] o_bus_addr, step, src, dst;
    logic [31:0] o_reg_rdata;
    logic [47:0] log_q[$];
    int n_mismatch = 0;
    int n_tests = 0;
    int n_rise = 0;
    int cyc = 0;
    int i, j, k;

    always #2 i_sys_clk = ~i_sys_clk;

    dct_channel dct_channel_i (
        .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
        .i_hw_req(i_hw_req), .i_bus_grant(i_bus_grant),
        .i_bus_ack(i_bus_ack), .i_bus_rdata(i_bus_rdata),
        .o_bus_req(o_bus_req), .o_bus_rd(o_bus_rd), .o_bus_wr(o_bus_wr),
        .o_bus_word(o_bus_word), .o_bus_addr(o_bus_addr),
        .o_bus_wdata(o_bus_wdata), .o_flyby_ack(o_flyby_ack),
        .o_irq(o_irq), .o_dma_clk_en(o_dma_clk_en));

    dct_bus_model dct_bus_model_i (
        .i_clk(i_sys_clk), .i_rst(i_sys_rst), .i_req(o_bus_req),
        .i_cyc(o_bus_rd | o_bus_wr), .i_addr(o_bus_addr), .i_dly(dly),
        .o_grant(i_bus_grant), .o_ack(i_bus_ack), .o_rdata(i_bus_rdata));

    // Log bus cycles, count requests and cut a hang short.
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        req_d <= o_bus_req;
        if (o_bus_req && !req_d)
            n_rise <= n_rise + 1;
        if (i_bus_ack && (o_bus_rd || o_bus_wr))
            log_q.push_back({5'h0, o_flyby_ack, o_bus_wr, o_bus_word,
                             o_bus_addr, o_bus_wdata});
        if (cyc == 20000) begin
            n_mismatch++;
            $display("CHECK FAILED %0t run too long", $time);
            finish_test();
        end
    end

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_sys_clk);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_reg_rd <= 1'b0;
        #1;
        chk(48'(o_reg_rdata), 48'(exp));
    endtask

    // Bounded wait; the step and idle cycles need a few more edges.
    task automatic wait_log(input int n);
        for (int w = 0; w < 300 && log_q.size() < n; w++)
            @(posedge i_sys_clk);
        repeat (4) @(posedge i_sys_clk);
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge i_sys_clk);
        i_sys_rst <= 1'b0;
        for (i = 0; i < 32; i++)
            rd(8'(i * 4), 32'h0);
        wr(dct_pkg::ADR_B_CUR, 32'hFFFF_FFFF);
        rd(dct_pkg::ADR_B_CUR, 32'h00FF_FFFF);
        wr(dct_pkg::ADR_A_CUR, 32'hFFFF_FFFF);
        rd(dct_pkg::ADR_A_CUR, 32'h00FF_FFFF);
        wr(dct_pkg::ADR_CTRL, 32'h0000_7FFE);
        rd(dct_pkg::ADR_CTRL, 32'h0000_7FFE);
        chk(48'(o_dma_clk_en), 48'h0);
        wr(dct_pkg::ADR_CTRL, 32'h0000_0000);
        wr(dct_pkg::ADR_STAT, 32'h0000_00FF);
        rd(dct_pkg::ADR_STAT, 32'h0);
        // Fly-by blocks of three: each step code, both directions.
        for (k = 0; k < 4; k++) begin
            step = (k == 0) ? 24'h1 : (k == 1) ? 24'h2 :
                   (k == 2) ? 24'hFFFFFF : 24'hFFFFFE;
            wr(dct_pkg::ADR_A_CUR, 32'h100);
            wr(dct_pkg::ADR_B_CUR, 32'h200);
            wr(dct_pkg::ADR_LEN_CUR, 32'h3);
            dly <= 4'(k * 2);
            i_hw_req <= (k == 2);
            log_q.delete();
            n_rise = 0;
            wr(dct_pkg::ADR_CTRL, 32'({3'b001, 2'(k), 1'b1, 1'(k != 2),
               1'(k == 3), 1'b0, 1'(k % 2), 5'b00111}));
            wait_log(3);
            i_hw_req <= 1'b0;
            chk(48'(log_q.size()), 48'd3);
            chk(48'(n_rise), 48'((k == 3) ? 1 : 3));
            for (i = 0; i < 3; i++)
                chk(48'(log_q[i][42:16]), 48'({2'b10 | 2'(k % 2), 1'b0,
                    24'(24'h100 + step * i)}));
            rd(dct_pkg::ADR_A_CUR, 32'(24'(24'h100 + step * 3)));
            rd(dct_pkg::ADR_B_CUR, 32'h200);
            rd(dct_pkg::ADR_LEN_CUR, 32'h0);
            rd(dct_pkg::ADR_STAT, 32'h3);
            chk(48'(o_irq), 48'h1);
            wr(dct_pkg::ADR_STAT, 32'h3);
            rd(dct_pkg::ADR_STAT, 32'h0);
            chk(48'(o_irq), 48'h0);
            wr(dct_pkg::ADR_CTRL, 32'h0);
        end
        // Memory to memory, words, B to A, then a reloaded second block.
        wr(dct_pkg::ADR_A_CUR, 32'h300);
        wr(dct_pkg::ADR_B_CUR, 32'h400);
        wr(dct_pkg::ADR_A_START, 32'h800);
        wr(dct_pkg::ADR_B_START, 32'h900);
        wr(dct_pkg::ADR_LEN_CUR, 32'h2);
        wr(dct_pkg::ADR_LEN_NEXT, 32'h3);
        rd(dct_pkg::ADR_STAT, 32'h8);
        log_q.delete();
        wr(dct_pkg::ADR_CTRL, 32'h0000_1F39);
        wait_log(10);
        chk(48'(log_q.size()), 48'd10);
        for (j = 0; j < 5; j++) begin
            src = (j < 2) ? 24'(24'h400 + j) : 24'(24'h900 + j - 2);
            dst = (j < 2) ? 24'(24'h300 - 2 * j) : 24'(24'h800 - 2 * (j - 2));
            chk(48'(log_q[2 * j][42:16]), {21'h0, 3'b001, src});
            chk(log_q[2 * j + 1], {5'h0, 3'b011, dst, src[15:0]});
        end
        rd(dct_pkg::ADR_A_CUR, 32'h7FA);
        rd(dct_pkg::ADR_B_CUR, 32'h903);
        rd(dct_pkg::ADR_STAT, 32'h3);
        chk(48'(o_irq), 48'h0);
        chk(48'(o_dma_clk_en), 48'h1);
        wr(dct_pkg::ADR_CTRL, 32'h0);
        #1;
        chk(48'(o_dma_clk_en), 48'h0);
        // Auto-init fly-by reads, started by an enable on an empty counter.
        // A hardware request is used so the software bit never changes.
        wr(dct_pkg::ADR_STAT, 32'h3);
        wr(dct_pkg::ADR_A_START, 32'h500);
        wr(dct_pkg::ADR_LEN_NEXT, 32'h1);
        log_q.delete();
        i_hw_req <= 1'b1;
        wr(dct_pkg::ADR_CTRL, 32'h0243);
        wait_log(2);
        chk(48'(o_irq), 48'h1);
        // Dropping the request lets any cycle in flight finish first.
        i_hw_req <= 1'b0;
        repeat (24) @(posedge i_sys_clk);
        wr(dct_pkg::ADR_CTRL, 32'h0);
        for (i = 0; i < 2; i++)
            chk(48'(log_q[i][42:16]), {21'h0, 3'b100, 24'h500});
        rd(dct_pkg::ADR_A_CUR, 32'h500);
        rd(dct_pkg::ADR_LEN_CUR, 32'h1);
        rd(dct_pkg::ADR_STAT, 32'h3);
        wr(dct_pkg::ADR_LEN_CUR, 32'h0);
        rd(dct_pkg::ADR_LEN_CUR, 32'hFFFF);
        finish_test();
    end
endmodule

bind dct_channel dct_channel_monitor dct_channel_monitor_i (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_bus_grant(i_bus_grant),
    .i_bus_ack(i_bus_ack), .o_bus_req(o_bus_req), .o_bus_rd(o_bus_rd),
    .o_bus_wr(o_bus_wr), .o_bus_word(o_bus_word), .o_bus_addr(o_bus_addr),
    .o_bus_wdata(o_bus_wdata), .o_flyby_ack(o_flyby_ack),
    .o_dma_clk_en(o_dma_clk_en));
